// ---- rtl/hpc_pkg.sv ----
// Purpose: Constants for the hub port configuration register slice
// Assumes: Byte-wide register port, offsets are register indices
// Notes: Field positions and multi-bit reset values live here; single-bit resets are 1'b0 literals
`default_nettype none
package hpc_pkg;
    localparam logic [7:0] HPC_OFS_REMOVABLE = 8'h07;
    localparam logic [7:0] HPC_OFS_PORT_USED = 8'h08;
    localparam logic [7:0] HPC_OFS_DEV_CFG2 = 8'h0a;
    localparam int HPC_PORTS = 4;
    localparam int HPC_BIT_RMBL_CUSTOM = 7;
    localparam int HPC_BIT_CHG_CUSTOM = 6;
    localparam int HPC_BIT_HI_CUR = 4;
    localparam int HPC_CFG2_RSVD_BIT = 7;
    localparam logic [3:0] HPC_USED_RESET = 4'hf;
    localparam logic [3:0] HPC_ZERO4 = 4'h0;
    localparam logic [2:0] HPC_ZERO3 = 3'h0;
    localparam logic [7:0] HPC_ZERO8 = 8'h00;
endpackage : hpc_pkg
`default_nettype wire

// ---- rtl/hpc_gated_field.sv ----
// Purpose: One customisable field: OTP value unless customised, else stored
// Assumes: Single clock domain, write strobe one cycle
// Notes: Stored value keeps its content while not customised
`default_nettype none
module hpc_gated_field #(
    parameter int W = 4,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic custom_next,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] otp_value,
    output logic [W-1:0] value
);
    logic [W-1:0] field_reg;
    logic [W-1:0] field_next;
    // Gate uses the post-write custom bit so both can change in one access
    assign field_next = (wr && custom_next) ? wdata : field_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            field_reg <= RST;
        end else if (ce) begin
            field_reg <= field_next;
        end
    end
    assign value = custom_next ? field_next : otp_value;
endmodule : hpc_gated_field
`default_nettype wire

// ---- rtl/hpc_regs.sv ----
// Purpose: Removable, port-used and second device configuration registers
// Assumes: Byte register port from SMBus slave or EEPROM loader, same clock
// Notes: OTP inputs are static straps from same-clock logic, not synchronised
`default_nettype none
module hpc_regs
    import hpc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [3:0] OTP_NON_REMOVABLE,
    input wire logic [3:0] OTP_PORT_USED,
    input wire logic [3:0] OTP_LEGACY_SPEED_ONLY,
    input wire logic OTP_HIGH_CURRENT,
    input wire logic [3:0] LEGACY_SPEED_ONLY_SET,
    output logic [7:0] REG_RDATA,
    output logic [3:0] PORT_REMOVABLE,
    output logic [3:0] PORT_ENABLE,
    output logic [3:0] PORT_USB2_ENABLE,
    output logic [3:0] PORT_LEGACY_SPEED_ONLY,
    output logic HIGH_CURRENT_DIVIDER_SELECT
);
    logic removable_custom_enable_reg;
    logic removable_custom_enable_next;
    logic charging_custom_enable_reg;
    logic charging_custom_enable_next;
    logic [7:0] rdata_next;
    logic [3:0] removable_value;
    logic [3:0] used_value;
    logic [3:0] legacy_reg;
    logic [3:0] legacy_next;
    logic [3:0] legacy_value;
    logic [0:0] hi_cur_value;
    logic wr_removable;
    logic wr_used;
    logic wr_cfg2;
    logic sel_removable;
    logic sel_used;
    logic sel_cfg2;

    assign sel_removable = (REG_ADDR == HPC_OFS_REMOVABLE);
    assign sel_used = (REG_ADDR == HPC_OFS_PORT_USED);
    assign sel_cfg2 = (REG_ADDR == HPC_OFS_DEV_CFG2);
    assign wr_removable = REG_WR && sel_removable;
    assign wr_used = REG_WR && sel_used;
    assign wr_cfg2 = REG_WR && sel_cfg2;

    assign removable_custom_enable_next = wr_removable ?
        REG_WDATA[HPC_BIT_RMBL_CUSTOM] : removable_custom_enable_reg;
    assign charging_custom_enable_next = wr_cfg2 ?
        REG_WDATA[HPC_BIT_CHG_CUSTOM] : charging_custom_enable_reg;

    // Removable field; OTP path is inverted non-removable
    hpc_gated_field #(.W(HPC_PORTS), .RST(HPC_ZERO4)) u_removable (
        .clk(CLOCK),
        .rst(RESET),
        .ce(CE),
        .custom_next(removable_custom_enable_next),
        .wr(wr_removable),
        .wdata(REG_WDATA[HPC_PORTS-1:0]),
        .otp_value(~OTP_NON_REMOVABLE),
        .value(removable_value)
    );

    hpc_gated_field #(.W(HPC_PORTS), .RST(HPC_USED_RESET)) u_used (
        .clk(CLOCK),
        .rst(RESET),
        .ce(CE),
        .custom_next(removable_custom_enable_next),
        .wr(wr_used),
        .wdata(REG_WDATA[HPC_PORTS-1:0]),
        .otp_value(OTP_PORT_USED),
        .value(used_value)
    );

    // Legacy field has no mapped offset; loader sets bits by strobe only while the removable custom enable is set, reset clears
    // Own store here: ORing into the shared field's output would loop combinationally
    assign legacy_next = removable_custom_enable_next ?
        (legacy_reg | LEGACY_SPEED_ONLY_SET) : legacy_reg;
    assign legacy_value = removable_custom_enable_next ?
        legacy_next : OTP_LEGACY_SPEED_ONLY;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            legacy_reg <= HPC_ZERO4;
        end else if (CE) begin
            legacy_reg <= legacy_next;
        end
    end

    hpc_gated_field #(.W(1), .RST(1'b0)) u_hi_cur (
        .clk(CLOCK),
        .rst(RESET),
        .ce(CE),
        .custom_next(charging_custom_enable_next),
        .wr(wr_cfg2),
        .wdata(REG_WDATA[HPC_BIT_HI_CUR]),
        .otp_value(OTP_HIGH_CURRENT),
        .value(hi_cur_value)
    );

    // Unmapped addresses read zero; only named bits ever change
    always_comb begin
        rdata_next = HPC_ZERO8;
        if (sel_removable) begin
            rdata_next = {removable_custom_enable_next, HPC_ZERO3, removable_value};
        end else if (sel_used) begin
            rdata_next = {HPC_ZERO4, used_value};
        end else if (sel_cfg2) begin
            rdata_next[HPC_BIT_CHG_CUSTOM] = charging_custom_enable_next;
            rdata_next[HPC_BIT_HI_CUR] = hi_cur_value[0];
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            removable_custom_enable_reg <= 1'b0;
            charging_custom_enable_reg <= 1'b0;
            REG_RDATA <= HPC_ZERO8;
            PORT_REMOVABLE <= HPC_ZERO4;
            PORT_ENABLE <= HPC_USED_RESET;
            PORT_USB2_ENABLE <= HPC_USED_RESET;
            PORT_LEGACY_SPEED_ONLY <= HPC_ZERO4;
            HIGH_CURRENT_DIVIDER_SELECT <= 1'b0;
        end else if (CE) begin
            removable_custom_enable_reg <= removable_custom_enable_next;
            charging_custom_enable_reg <= charging_custom_enable_next;
            if (REG_RD) begin
                REG_RDATA <= rdata_next;
            end
            PORT_REMOVABLE <= removable_value;
            PORT_ENABLE <= used_value;
            PORT_USB2_ENABLE <= used_value | legacy_value;
            PORT_LEGACY_SPEED_ONLY <= legacy_value;
            HIGH_CURRENT_DIVIDER_SELECT <= hi_cur_value[0];
        end
    end

    // Output checks look one edge after the access that caused them
    sequence s_rmbl_custom_write;
        CE && wr_removable && REG_WDATA[HPC_BIT_RMBL_CUSTOM];
    endsequence

    sequence s_rmbl_applied;
        removable_custom_enable_reg &&
            (PORT_REMOVABLE == $past(REG_WDATA[HPC_PORTS-1:0]));
    endsequence

    sequence s_chg_custom_write;
        CE && wr_cfg2 && REG_WDATA[HPC_BIT_CHG_CUSTOM];
    endsequence

    sequence s_chg_applied;
        charging_custom_enable_reg &&
            (HIGH_CURRENT_DIVIDER_SELECT == $past(REG_WDATA[HPC_BIT_HI_CUR]));
    endsequence

    property p_usb2_forced;
        @(posedge CLOCK) disable iff (RESET)
        PORT_USB2_ENABLE == (PORT_ENABLE | PORT_LEGACY_SPEED_ONLY);
    endproperty
    a_usb2_forced: assert property (p_usb2_forced)
        else $error("USB2 enable not forced for a legacy-only port");

    property p_rmbl_write;
        @(posedge CLOCK) disable iff (RESET)
        s_rmbl_custom_write |=> s_rmbl_applied;
    endproperty
    a_rmbl_write: assert property (p_rmbl_write)
        else $error("Customising write did not land the removable bits");

    property p_rmbl_otp;
        @(posedge CLOCK) disable iff (RESET)
        CE && !removable_custom_enable_next |=>
            PORT_REMOVABLE == ~$past(OTP_NON_REMOVABLE);
    endproperty
    a_rmbl_otp: assert property (p_rmbl_otp)
        else $error("Uncustomised removable bits differ from inverted storage");

    property p_used_otp;
        @(posedge CLOCK) disable iff (RESET)
        CE && !removable_custom_enable_next |=>
            PORT_ENABLE == $past(OTP_PORT_USED);
    endproperty
    a_used_otp: assert property (p_used_otp)
        else $error("Uncustomised port enables differ from storage");

    property p_rmbl_readback;
        @(posedge CLOCK) disable iff (RESET)
        CE && REG_RD && sel_removable |=>
            REG_RDATA == {removable_custom_enable_reg, HPC_ZERO3, PORT_REMOVABLE};
    endproperty
    a_rmbl_readback: assert property (p_rmbl_readback)
        else $error("Removable register readback wrong or reserved bits set");

    property p_cfg2_rsvd;
        @(posedge CLOCK) disable iff (RESET)
        CE && REG_RD && sel_cfg2 |=>
            !REG_RDATA[HPC_CFG2_RSVD_BIT] &&
            (REG_RDATA[HPC_BIT_HI_CUR] == HIGH_CURRENT_DIVIDER_SELECT);
    endproperty
    a_cfg2_rsvd: assert property (p_cfg2_rsvd)
        else $error("Second configuration readback wrong or reserved bit set");

    property p_hi_cur_otp;
        @(posedge CLOCK) disable iff (RESET)
        CE && !charging_custom_enable_next |=>
            HIGH_CURRENT_DIVIDER_SELECT == $past(OTP_HIGH_CURRENT);
    endproperty
    a_hi_cur_otp: assert property (p_hi_cur_otp)
        else $error("Uncustomised divider select differs from storage");

    property p_hi_cur_write;
        @(posedge CLOCK) disable iff (RESET)
        s_chg_custom_write |=> s_chg_applied;
    endproperty
    a_hi_cur_write: assert property (p_hi_cur_write)
        else $error("Customising write did not land the divider select");

    // Async reset is the only thing allowed to move state with the enable low
    property p_ce_freeze;
        @(posedge CLOCK) disable iff (RESET)
        !CE |=> $stable(REG_RDATA) && $stable(PORT_REMOVABLE) && $stable(PORT_ENABLE) &&
            $stable(PORT_LEGACY_SPEED_ONLY) && $stable(HIGH_CURRENT_DIVIDER_SELECT);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) // Low clock enable holds every output except PORT_USB2_ENABLE, which is not checked
        else $error("Output moved while clock enable was low");
endmodule : hpc_regs
`default_nettype wire

// ---- dv/hpc_otp_model.sv ----
// Purpose: Static OTP storage contents seen by the register slice
// Assumes: Values stay fixed for the whole run
// Notes: Picked so OTP readback differs from reset values and, except high current, from written values
`default_nettype none
module hpc_otp_model #(
    parameter logic [3:0] NON_RMBL = 4'h3,
    parameter logic HI = 1'b1
) (
    output logic [3:0] otp_non_removable,
    output logic [3:0] otp_port_used,
    output logic [3:0] otp_legacy,
    output logic otp_high_current
);
    assign otp_non_removable = NON_RMBL;
    assign otp_port_used = 4'h6;
    assign otp_legacy = 4'h8;
    assign otp_high_current = HI;
endmodule // hpc_otp_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Directed register tests of the hub port configuration slice
// Assumes: OTP values come from the storage model
// Notes: CE dropped once to check freeze; tasks wait out the output lag
`default_nettype none
module tb_top
    import hpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] lso_set = 4'h0;
    logic ce = 1'b1;
    wire logic [7:0] rdata;
    wire logic [3:0] rmbl, en, usb2, lso, otp_nr, otp_used, otp_lso;
    wire logic otp_hi, hcds;
    int num_errors = 0;
    int comparisons = 0;
    hpc_otp_model OTP (.otp_non_removable(otp_nr), .otp_port_used(otp_used),
        .otp_legacy(otp_lso), .otp_high_current(otp_hi));
    hpc_regs DUT (.CLOCK(clk), .RESET(rst), .CE(ce), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .OTP_NON_REMOVABLE(otp_nr),
        .OTP_PORT_USED(otp_used), .OTP_LEGACY_SPEED_ONLY(otp_lso),
        .OTP_HIGH_CURRENT(otp_hi), .LEGACY_SPEED_ONLY_SET(lso_set), .REG_RDATA(rdata),
        .PORT_REMOVABLE(rmbl), .PORT_ENABLE(en), .PORT_USB2_ENABLE(usb2),
        .PORT_LEGACY_SPEED_ONLY(lso), .HIGH_CURRENT_DIVIDER_SELECT(hcds));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 chk(rdata, exp);
    endtask
    task automatic pulse_lso(input logic [3:0] v);
        @(posedge clk);
        lso_set <= v;
        @(posedge clk);
        lso_set <= 4'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic results();
        $display("Errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #20us;
        num_errors++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(HPC_OFS_REMOVABLE, 8'h0c);
        rd_reg(HPC_OFS_PORT_USED, 8'h06);
        rd_reg(HPC_OFS_DEV_CFG2, 8'h10);
        chk({4'h0, usb2}, 8'h0e);
        chk({4'h0, lso}, 8'h08);
        // Custom bit stays clear, so the removable write must not land
        wr_reg(HPC_OFS_REMOVABLE, 8'h7a);
        rd_reg(HPC_OFS_REMOVABLE, 8'h0c);
        wr_reg(HPC_OFS_REMOVABLE, 8'hf5);
        rd_reg(HPC_OFS_REMOVABLE, 8'h85);
        chk({4'h0, rmbl}, 8'h05);
        rd_reg(HPC_OFS_PORT_USED, 8'h0f);
        chk({4'h0, lso}, 8'h00);
        wr_reg(HPC_OFS_PORT_USED, 8'hf3);
        rd_reg(HPC_OFS_PORT_USED, 8'h03);
        chk({4'h0, en}, 8'h03);
        pulse_lso(4'h4);
        chk({4'h0, usb2}, 8'h07);
        chk({4'h0, lso}, 8'h04);
        chk({4'h0, en}, 8'h03);
        // Frozen enable must swallow a write that would clear customisation
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(HPC_OFS_REMOVABLE, 8'h0a);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(HPC_OFS_REMOVABLE, 8'h85);
        chk({4'h0, rmbl}, 8'h05);
        wr_reg(HPC_OFS_DEV_CFG2, 8'hc0);
        rd_reg(HPC_OFS_DEV_CFG2, 8'h40);
        chk({7'h0, hcds}, 8'h00);
        wr_reg(HPC_OFS_DEV_CFG2, 8'h50);
        rd_reg(HPC_OFS_DEV_CFG2, 8'h50);
        chk({7'h0, hcds}, 8'h01);
        wr_reg(HPC_OFS_DEV_CFG2, 8'h80);
        rd_reg(HPC_OFS_DEV_CFG2, 8'h10);
        chk({7'h0, hcds}, 8'h01);
        rd_reg(8'h09, 8'h00);
        // Second reset drops customisation and reloads the used bits' reset value 0xf
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk({4'h0, en}, 8'h0f);
        rd_reg(HPC_OFS_REMOVABLE, 8'h0c);
        pulse_lso(4'h2);
        chk({4'h0, lso}, 8'h08);
        wr_reg(HPC_OFS_REMOVABLE, 8'h80);
        rd_reg(HPC_OFS_PORT_USED, 8'h0f);
        chk({4'h0, lso}, 8'h00);
        results();
    end
endmodule // tb_top
`default_nettype wire
